// ===== rtl/tdc_addr_step.sv
// tdc_addr_step: next byte address for increment, decrement or fixed
`timescale 1ns/1ps
module tdc_addr_step (
   // current address and modifier
   input wire logic [19:0] addr_i,
   input wire logic [1:0] mode_i,
   // address for the following byte
   output logic [19:0] next_o
);
   import tdc_pkg::*;

   // full 20-bit carry, so 64k pages are crossed without help
   always_comb begin
      if (mode_i == AM_INC) begin
         next_o = addr_i + 20'h00001;
      end else if (mode_i == AM_DEC) begin
         next_o = addr_i - 20'h00001;
      end else begin
         next_o = addr_i;
      end
   end
endmodule // tdc_addr_step

// ===== rtl/tdc_dma.sv
// tdc_dma: two-channel byte dma controller with its register file
// Summary of operation
// - 20-bit memory addresses, carry across 64k
// - i/o accesses drive 16-bit address
// - 16-bit counter, decrement per byte, stop at zero
// - three cycles per byte, waits stretch them
// - request detection selectable level or edge
// - per-channel end-of-transfer output
// - channel 0 wins simultaneous requests
// - channel 1 moves memory to/from i/o only
// - run needs channel and main enable; auto-clear
// - enable low with irq enable raises interrupt
// - enable written only with gate bit zero
// - writing enable 1 sets main; 0 pauses
// - main enable read-only, nmi clears it
// - reset clears enables and channel 0 modes
// - destination mode field selects target, modifier
// - source mode field, same encoding
// - channel 0 i/o transfers paced by request
// - bus mode 1 bursts, 0 steals cycles
// - sense bit 0 level, 1 edge; reset clears
// - channel 1 mode: direction and memory step
// - end output low during final write cycle
`timescale 1ns/1ps
module tdc_dma (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // internal register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // processor events
   input wire logic nmi_i,
   // system bus
   input wire logic bus_wait_i,
   input wire logic [7:0] bus_rdata_i,
   output logic [19:0] bus_addr_o,
   output logic [7:0] bus_wdata_o,
   output logic bus_mem_o,
   output logic bus_io_o,
   output logic bus_rd_o,
   output logic bus_wr_o,
   output logic bus_hold_o,
   // channel pins and interrupt requests
   input wire logic [1:0] transfer_request_n_i,
   output logic [1:0] transfer_end_n_o,
   output logic [1:0] term_irq_o
);
   import tdc_pkg::*;

   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
                                input logic [1:0] len);
      return (a >= base) && (a < (base + {6'h00, len}));
   endfunction

   function automatic logic [1:0] lane(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      return d[1:0];
   endfunction

   function automatic logic [19:0] put(input logic [19:0] v, input logic [1:0] l,
                                       input logic [7:0] b);
      logic [19:0] r;
      r = v;
      if (l == 2'd0) begin
         r[7:0] = b;
      end else if (l == 2'd1) begin
         r[15:8] = b;
      end else begin
         r[19:16] = b[3:0];
      end
      return r;
   endfunction

   function automatic logic [7:0] get(input logic [19:0] v, input logic [1:0] l);
      if (l == 2'd0) return v[7:0];
      else if (l == 2'd1) return v[15:8];
      else return {4'h0, v[19:16]};
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [1:0] s1_q, s1_d, s2_q, s2_d;
   logic [19:0] src0_q, src0_d, dst0_q, dst0_d, mem1_q, mem1_d;
   logic [15:0] io1_q, io1_d, cnt0_q, cnt0_d, cnt1_q, cnt1_d;
   logic [19:0] t20;
   logic [1:0] en_q, en_d, ie_q, ie_d;
   logic me_q, me_d;
   logic [1:0] dm_q, dm_d, sm_q, sm_d;
   logic burst_q, burst_d;
   logic [7:0] ctrl_q, ctrl_d;
   tdc_state_t st_q, st_d;
   logic ch_q, ch_d;
   logic [7:0] data_q, data_d;
   logic [7:0] rdata_d;
   logic [19:0] addr_d;
   logic [7:0] wdata_d;
   logic mem_d, io_d, rd_d, wr_d, hold_d;
   logic [1:0] transfer_end_n_d, irq_d;
   logic [1:0] take, pend, sense;
   logic [19:0] src0_nx, dst0_nx, mem1_nx;
   logic src_io0, dst_io0, paced0, rdy0, rdy1, ch1_in, cnt_last;

   // ---------------------------------------------------------------
   // request pins: two flops before any detector reads them
   // ---------------------------------------------------------------
   always_comb begin
      s1_d = ~transfer_request_n_i;
      s2_d = s1_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 2'b00;
         s2_q <= 2'b00;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end

   // one detector per channel, sense vector indexed by channel, reverse of the control register bit order
   assign sense = {ctrl_q[CTRL_SENSE1], ctrl_q[CTRL_SENSE0]};
   tdc_req_if req_if[2] ();
   for (genvar c = 0; c < 2; c++) begin : g_req
      assign req_if[c].req_on = s2_q[c];
      assign req_if[c].edge_sense = sense[c];
      assign req_if[c].take = take[c];
      assign pend[c] = req_if[c].pending;
      tdc_req_detect u_det (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .req(req_if[c])
      );
   end

   // ---------------------------------------------------------------
   // address steppers
   // ---------------------------------------------------------------
   tdc_addr_step u_src0 (.addr_i(src0_q), .mode_i(sm_q), .next_o(src0_nx));
   tdc_addr_step u_dst0 (.addr_i(dst0_q), .mode_i(dm_q), .next_o(dst0_nx));
   tdc_addr_step u_mem1 (
      .addr_i(mem1_q),
      .mode_i({1'b0, ctrl_q[CTRL_DEC]}),
      .next_o(mem1_nx)
   );

   // channel readiness; fixed-address modes are paced by the request
   assign src_io0 = (sm_q == AM_IO);
   assign dst_io0 = (dm_q == AM_IO);
   assign paced0 = sm_q[1] | dm_q[1];
   assign rdy0 = en_q[0] & me_q & (~paced0 | pend[0]);
   assign rdy1 = en_q[1] & me_q & pend[1];
   assign ch1_in = ctrl_q[CTRL_DIR];

   // ---------------------------------------------------------------
   // engine and register file
   // ---------------------------------------------------------------
   always_comb begin
      src0_d = src0_q;
      dst0_d = dst0_q;
      mem1_d = mem1_q;
      io1_d = io1_q;
      cnt0_d = cnt0_q;
      cnt1_d = cnt1_q;
      en_d = en_q;
      ie_d = ie_q;
      me_d = me_q;
      dm_d = dm_q;
      sm_d = sm_q;
      burst_d = burst_q;
      ctrl_d = ctrl_q;
      st_d = st_q;
      ch_d = ch_q;
      data_d = data_q;
      take = 2'b00;
      t20 = 20'h00000;
      // byte sequence: read, write, update (three cycles)
      case (st_q)
         ST_IDLE: begin
            if (rdy0) begin
               ch_d = 1'b0;
               st_d = ST_READ;
               take[0] = 1'b1;
            end else if (rdy1) begin
               ch_d = 1'b1;
               st_d = ST_READ;
               take[1] = 1'b1;
            end
         end
         ST_READ: begin
            if (!bus_wait_i) begin
               data_d = bus_rdata_i;
               st_d = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (!bus_wait_i) st_d = ST_UPDATE;
         end
         ST_UPDATE: begin
            st_d = ST_IDLE;
            if (!ch_q) begin
               src0_d = src0_nx;
               dst0_d = dst0_nx;
               cnt0_d = cnt0_q - 16'h0001;
               if (cnt0_d == 16'h0000) en_d[0] = 1'b0;
               // burst keeps the bus when neither address is fixed; else one idle slot
               if (burst_q && !paced0 && en_d[0] && me_q) st_d = ST_READ;
            end else begin
               mem1_d = mem1_nx;
               cnt1_d = cnt1_q - 16'h0001;
               if (cnt1_d == 16'h0000) en_d[1] = 1'b0;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      // nmi drops the main enable; an enable write below sets it again
      if (nmi_i) me_d = 1'b0;
      // software writes land last and win over the engine's update
      if (reg_wr_i) begin
         if (hit(reg_addr_i, ADDR_SRC0, LEN_ADDR)) begin
            src0_d = put(src0_q, lane(reg_addr_i, ADDR_SRC0), reg_wdata_i);
         end else if (hit(reg_addr_i, ADDR_DST0, LEN_ADDR)) begin
            dst0_d = put(dst0_q, lane(reg_addr_i, ADDR_DST0), reg_wdata_i);
         end else if (hit(reg_addr_i, ADDR_CNT0, LEN_WORD)) begin
            t20 = put({4'h0, cnt0_q}, lane(reg_addr_i, ADDR_CNT0), reg_wdata_i);
            cnt0_d = t20[15:0];
         end else if (hit(reg_addr_i, ADDR_MEM1, LEN_ADDR)) begin
            mem1_d = put(mem1_q, lane(reg_addr_i, ADDR_MEM1), reg_wdata_i);
         end else if (hit(reg_addr_i, ADDR_IO1, LEN_WORD)) begin
            t20 = put({4'h0, io1_q}, lane(reg_addr_i, ADDR_IO1), reg_wdata_i);
            io1_d = t20[15:0];
         end else if (hit(reg_addr_i, ADDR_CNT1, LEN_WORD)) begin
            t20 = put({4'h0, cnt1_q}, lane(reg_addr_i, ADDR_CNT1), reg_wdata_i);
            cnt1_d = t20[15:0];
         end else if (reg_addr_i == ADDR_STAT) begin
            if (!reg_wdata_i[STAT_WG1]) begin
               en_d[1] = reg_wdata_i[STAT_EN1];
               if (reg_wdata_i[STAT_EN1]) me_d = 1'b1;
            end
            if (!reg_wdata_i[STAT_WG0]) begin
               en_d[0] = reg_wdata_i[STAT_EN0];
               if (reg_wdata_i[STAT_EN0]) me_d = 1'b1;
            end
            ie_d = {reg_wdata_i[STAT_IE1], reg_wdata_i[STAT_IE0]};
         end else if (reg_addr_i == ADDR_MODE) begin
            dm_d = reg_wdata_i[MODE_DST +: 2];
            sm_d = reg_wdata_i[MODE_SRC +: 2];
            burst_d = reg_wdata_i[MODE_BUS];
         end else if (reg_addr_i == ADDR_CTRL) begin
            ctrl_d = reg_wdata_i;
         end
      end
      // read port: gate bits read as one, holes and unused bits outside the control register as zero
      rdata_d = 8'h00;
      if (hit(reg_addr_i, ADDR_SRC0, LEN_ADDR)) begin
         rdata_d = get(src0_q, lane(reg_addr_i, ADDR_SRC0));
      end else if (hit(reg_addr_i, ADDR_DST0, LEN_ADDR)) begin
         rdata_d = get(dst0_q, lane(reg_addr_i, ADDR_DST0));
      end else if (hit(reg_addr_i, ADDR_CNT0, LEN_WORD)) begin
         rdata_d = get({4'h0, cnt0_q}, lane(reg_addr_i, ADDR_CNT0));
      end else if (hit(reg_addr_i, ADDR_MEM1, LEN_ADDR)) begin
         rdata_d = get(mem1_q, lane(reg_addr_i, ADDR_MEM1));
      end else if (hit(reg_addr_i, ADDR_IO1, LEN_WORD)) begin
         rdata_d = get({4'h0, io1_q}, lane(reg_addr_i, ADDR_IO1));
      end else if (hit(reg_addr_i, ADDR_CNT1, LEN_WORD)) begin
         rdata_d = get({4'h0, cnt1_q}, lane(reg_addr_i, ADDR_CNT1));
      end else if (reg_addr_i == ADDR_STAT) begin
         rdata_d = {en_q, 2'b11, ie_q, 1'b0, me_q};
      end else if (reg_addr_i == ADDR_MODE) begin
         rdata_d = {2'b00, dm_q, sm_q, burst_q, 1'b0};
      end else if (reg_addr_i == ADDR_CTRL) begin
         rdata_d = ctrl_q;
      end
      // bus drive for the coming cycle, from next-cycle addresses
      addr_d = 20'h00000;
      io_d = 1'b0;
      rd_d = (st_d == ST_READ);
      wr_d = (st_d == ST_WRITE);
      if (rd_d && !ch_d) begin
         io_d = src_io0;
         addr_d = src_io0 ? {4'h0, src0_d[15:0]} : src0_d;
      end else if (wr_d && !ch_d) begin
         io_d = dst_io0;
         addr_d = dst_io0 ? {4'h0, dst0_d[15:0]} : dst0_d;
      end else if (rd_d || wr_d) begin
         io_d = (rd_d == ch1_in);
         addr_d = io_d ? {4'h0, io1_d} : mem1_d;
      end
      mem_d = (rd_d | wr_d) & ~io_d;
      wdata_d = wr_d ? data_d : 8'h00;
      // cycle steal: the idle slot hands the bus back to execution
      hold_d = (st_d != ST_IDLE);
      cnt_last = ch_d ? (cnt1_q == 16'h0001) : (cnt0_q == 16'h0001);
      transfer_end_n_d = 2'b11;
      if (wr_d && cnt_last) transfer_end_n_d[ch_d] = 1'b0;
      irq_d = ~en_d & ie_d;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src0_q <= 20'h00000;
         dst0_q <= 20'h00000;
         mem1_q <= 20'h00000;
         io1_q <= 16'h0000;
         cnt0_q <= 16'h0000;
         cnt1_q <= 16'h0000;
         en_q <= 2'b00;
         ie_q <= 2'b00;
         me_q <= 1'b0;
         dm_q <= AM_INC;
         sm_q <= AM_INC;
         burst_q <= 1'b0;
         ctrl_q <= CTRL_RESET;
         st_q <= ST_IDLE;
         ch_q <= 1'b0;
         data_q <= 8'h00;
         reg_rdata_o <= 8'h00;
         bus_addr_o <= 20'h00000;
         bus_wdata_o <= 8'h00;
         bus_mem_o <= 1'b0;
         bus_io_o <= 1'b0;
         bus_rd_o <= 1'b0;
         bus_wr_o <= 1'b0;
         bus_hold_o <= 1'b0;
         transfer_end_n_o <= 2'b11;
         term_irq_o <= 2'b00;
      end else begin
         src0_q <= src0_d;
         dst0_q <= dst0_d;
         mem1_q <= mem1_d;
         io1_q <= io1_d;
         cnt0_q <= cnt0_d;
         cnt1_q <= cnt1_d;
         en_q <= en_d;
         ie_q <= ie_d;
         me_q <= me_d;
         dm_q <= dm_d;
         sm_q <= sm_d;
         burst_q <= burst_d;
         ctrl_q <= ctrl_d;
         st_q <= st_d;
         ch_q <= ch_d;
         data_q <= data_d;
         reg_rdata_o <= rdata_d;
         bus_addr_o <= addr_d;
         bus_wdata_o <= wdata_d;
         bus_mem_o <= mem_d;
         bus_io_o <= io_d;
         bus_rd_o <= rd_d;
         bus_wr_o <= wr_d;
         bus_hold_o <= hold_d;
         transfer_end_n_o <= transfer_end_n_d;
         term_irq_o <= irq_d;
      end
   end
endmodule // tdc_dma

// ===== rtl/tdc_pkg.sv
// tdc_pkg: register map, field positions and codes of the two-channel byte dma
package tdc_pkg;
   // ---------------------------------------------------------------
   // register byte addresses (multi-byte registers, low byte first)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_SRC0 = 8'h20;
   localparam logic [7:0] ADDR_DST0 = 8'h23;
   localparam logic [7:0] ADDR_CNT0 = 8'h26;
   localparam logic [7:0] ADDR_MEM1 = 8'h28;
   localparam logic [7:0] ADDR_IO1 = 8'h2b;
   localparam logic [7:0] ADDR_CNT1 = 8'h2e;
   localparam logic [7:0] ADDR_STAT = 8'h30;
   localparam logic [7:0] ADDR_MODE = 8'h31;
   localparam logic [7:0] ADDR_CTRL = 8'h32;
   localparam logic [1:0] LEN_ADDR = 2'd3;
   localparam logic [1:0] LEN_WORD = 2'd2;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int STAT_EN1 = 7;
   localparam int STAT_EN0 = 6;
   localparam int STAT_WG1 = 5;
   localparam int STAT_WG0 = 4;
   localparam int STAT_IE1 = 3;
   localparam int STAT_IE0 = 2;
   localparam int STAT_ME = 0;
   localparam int MODE_DST = 4;
   localparam int MODE_SRC = 2;
   localparam int MODE_BUS = 1;
   localparam int CTRL_SENSE0 = 3;
   localparam int CTRL_SENSE1 = 2;
   localparam int CTRL_DIR = 1;
   localparam int CTRL_DEC = 0;
   // ---------------------------------------------------------------
   // address modifier codes, reset values, timing
   // ---------------------------------------------------------------
   localparam logic [1:0] AM_INC = 2'b00;
   localparam logic [1:0] AM_DEC = 2'b01;
   localparam logic [1:0] AM_IO = 2'b11;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int BYTE_CYCLES = 3;
   typedef enum {ST_IDLE, ST_READ, ST_WRITE, ST_UPDATE} tdc_state_t;
endpackage

// ===== rtl/tdc_req_detect.sv
// tdc_req_detect: level or edge detection of one transfer request
`timescale 1ns/1ps
module tdc_req_detect (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // request channel
   tdc_req_if.det req
);
   logic last_q, last_d, edge_q, edge_d;

   // an edge in the same cycle as take stays latched
   always_comb begin
      last_d = req.req_on;
      edge_d = edge_q;
      if (req.take) edge_d = 1'b0;
      if (req.req_on && !last_q) edge_d = 1'b1;
   end

   // register detector state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_q <= 1'b0;
         edge_q <= 1'b0;
      end else begin
         last_q <= last_d;
         edge_q <= edge_d;
      end
   end

   // sense 0 follows the level, sense 1 the latched edge
   assign req.pending = req.edge_sense ? edge_q : req.req_on;
endmodule // tdc_req_detect

// ===== rtl/tdc_req_if.sv
// tdc_req_if: request line, sense select and pending flag of one channel
`timescale 1ns/1ps
interface tdc_req_if;
   logic req_on;
   logic edge_sense;
   logic take;
   logic pending;
   modport det (input req_on, edge_sense, take, output pending);
   modport ctl (output req_on, edge_sense, take, input pending);
endinterface

// ===== tb/tdc_bus_partner.sv
// tdc_bus_partner: memory and i/o peripheral model on the dma bus
`timescale 1ns/1ps
module tdc_bus_partner (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // test controls
   input wire logic slow_i,
   input wire logic [1:0] want_i,
   // dma bus
   input wire logic [19:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic bus_io_i,
   input wire logic bus_rd_i,
   input wire logic bus_wr_i,
   input wire logic [1:0] end_n_i,
   output logic bus_wait_o,
   output logic [7:0] bus_rdata_o,
   output logic [1:0] req_n_o
);
   logic ph_q;
   logic [7:0] last_q;
   logic [29:0] log_q[$];
   int cyc_q[$];
   int cyc = 0;
   // one wait state per strobe when slow, so every access gets stretched
   assign bus_wait_o = slow_i && (bus_rd_i || bus_wr_i) && !ph_q;
   // data follows address; an idle bus shows the inverse of the last byte
   assign bus_rdata_o = bus_rd_i ? (bus_addr_i[7:0] ^ 8'h5a) : ~last_q;
   // request held low while the peripheral wants service
   assign req_n_o = ~want_i;
   // log every completed write with its cycle stamp; a plain process, since the
   // bench empties the queues between scenarios
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      ph_q <= bus_wait_o;
      last_q <= rst_i ? 8'h00 : bus_rdata_o;
      if (bus_wr_i && !bus_wait_o) begin
         log_q.push_back({bus_io_i, &end_n_i, bus_addr_i, bus_wdata_i});
         cyc_q.push_back(cyc);
      end
   end
endmodule // tdc_bus_partner

// ===== tb/tdc_dma_monitor.sv
// tdc_dma_monitor: bus and register port assertions of the dma block
`timescale 1ns/1ps
module tdc_dma_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_rdata_o,
   // system bus and pins
   input wire logic bus_wait_i,
   input wire logic [19:0] bus_addr_o,
   input wire logic bus_mem_o,
   input wire logic bus_io_o,
   input wire logic bus_rd_o,
   input wire logic bus_wr_o,
   input wire logic bus_hold_o,
   input wire logic [1:0] transfer_end_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ------
   // byte steps
   // ------
   sequence s_rd_end; bus_rd_o && !bus_wait_i; endsequence
   sequence s_wr_end; bus_wr_o && !bus_wait_i; endsequence
   sequence s_update; bus_hold_o && !bus_rd_o && !bus_wr_o; endsequence
   // ------
   // properties
   // ------
   property p_rd_then_wr; s_rd_end |=> bus_wr_o; endproperty
   a_rd_then_wr: assert property (p_rd_then_wr)
      else $error("write did not follow read");
   property p_wr_then_upd; s_wr_end |=> s_update; endproperty
   a_wr_then_upd: assert property (p_wr_then_upd)
      else $error("update cycle missing after write");
   property p_wait_hold; bus_rd_o && bus_wait_i |=> bus_rd_o && $stable(bus_addr_o); endproperty
   a_wait_hold: assert property (p_wait_hold)
      else $error("read not stretched by wait");
   property p_io_addr; bus_io_o |-> bus_addr_o[19:16] == 4'h0; endproperty
   a_io_addr: assert property (p_io_addr)
      else $error("i/o address wider than 16 bits");
   property p_space; (bus_rd_o || bus_wr_o) |-> (bus_mem_o != bus_io_o) && bus_hold_o; endproperty
   a_space: assert property (p_space)
      else $error("access without one address space");
   property p_end_write; transfer_end_n_o != 2'b11 |-> bus_wr_o; endproperty
   a_end_write: assert property (p_end_write)
      else $error("end output low outside write");
   property p_end_clear; s_wr_end ##0 transfer_end_n_o != 2'b11 |=> transfer_end_n_o == 2'b11;
   endproperty
   a_end_clear: assert property (p_end_clear)
      else $error("end output stuck low");
   property p_gate_read; reg_addr_i == 8'h30 |=> reg_rdata_o[5:4] == 2'b11; endproperty
   a_gate_read: assert property (p_gate_read)
      else $error("write gate bits not read as ones");
endmodule // tdc_dma_monitor

// ===== tb/testbench.sv
// testbench: register and transfer scenarios of the two-channel dma
`timescale 1ns/1ps
module testbench;
   import tdc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic nmi_i = 1'b0;
   logic slow = 1'b0;
   logic [1:0] want = 2'b00;
   logic [7:0] reg_rdata_o, bus_rdata_i, bus_wdata_o;
   logic bus_wait_i, bus_mem_o, bus_io_o, bus_rd_o, bus_wr_o, bus_hold_o;
   logic [19:0] bus_addr_o;
   logic [1:0] transfer_request_n_i, transfer_end_n_o, term_irq_o;
   int fails = 0;
   int n_checks = 0;
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   tdc_dma dut (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .nmi_i,
      .bus_wait_i, .bus_rdata_i, .bus_addr_o, .bus_wdata_o, .bus_mem_o, .bus_io_o, .bus_rd_o,
      .bus_wr_o, .bus_hold_o, .transfer_request_n_i, .transfer_end_n_o, .term_irq_o);
   tdc_bus_partner p (.clk_i, .rst_i, .slow_i(slow), .want_i(want), .bus_addr_i(bus_addr_o),
      .bus_wdata_i(bus_wdata_o), .bus_io_i(bus_io_o), .bus_rd_i(bus_rd_o), .bus_wr_i(bus_wr_o),
      .end_n_i(transfer_end_n_o), .bus_wait_o(bus_wait_i), .bus_rdata_o(bus_rdata_i),
      .req_n_o(transfer_request_n_i));
   // ------
   // shared tasks
   // ------
   task automatic wrap_up();
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // multi-byte registers go low byte first, one byte per cycle
   task automatic wr_reg(input logic [7:0] a, input logic [23:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         reg_addr_i <= a + 8'(i);
         reg_wdata_i <= v[8*i +: 8];
         reg_wr_i <= 1'b1;
      end
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      reg_addr_i <= a;
      @(posedge clk_i);
      #1;
      chk({24'h0, reg_rdata_o}, {24'h0, exp});
   endtask
   task automatic chk_log(input int i, input logic [29:0] exp);
      chk({2'b0, p.log_q[i]}, {2'b0, exp});
   endtask
   task automatic pulse_nmi();
      @(posedge clk_i);
      nmi_i <= 1'b1;
      @(posedge clk_i);
      nmi_i <= 1'b0;
   endtask
   // poll the status register until the masked enables drop
   task automatic wait_idle(input logic [7:0] mask);
      logic busy;
      busy = 1'b1;
      @(posedge clk_i);
      reg_addr_i <= ADDR_STAT;
      for (int k = 0; k < 400 && busy; k++) begin
         @(posedge clk_i);
         #1;
         busy = (reg_rdata_o & mask) !== 8'h00;
      end
      if (busy) begin
         fails++;
         wrap_up();
      end
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_reset();
      chk({30'h0, transfer_end_n_o}, 32'h3);
      chk({30'h0, term_irq_o}, 32'h0);
      chk_reg(ADDR_STAT, 8'h30);
      chk_reg(ADDR_MODE, 8'h00);
      chk_reg(ADDR_CTRL, 8'h00);
      chk_reg(8'h2d, 8'h00);
      wr_reg(ADDR_SRC0 + 8'h2, 24'hff, 1);
      chk_reg(ADDR_SRC0 + 8'h2, 8'h0f);
   endtask
   // burst across a 64k boundary, destination counting down
   task automatic t_burst();
      p.log_q.delete();
      p.cyc_q.delete();
      wr_reg(ADDR_SRC0, 24'h00fffe, 3);
      wr_reg(ADDR_DST0, 24'h020000, 3);
      wr_reg(ADDR_CNT0, 24'h3, 2);
      wr_reg(ADDR_MODE, 24'h12, 1);
      wr_reg(ADDR_STAT, 24'h44, 1);
      wait_idle(8'h40);
      chk_log(0, {2'b01, 20'h20000, 8'ha4});
      chk_log(1, {2'b01, 20'h1ffff, 8'ha5});
      chk_log(2, {2'b00, 20'h1fffe, 8'h5a});
      chk(p.cyc_q[1] - p.cyc_q[0], 32'd3);
      chk(p.cyc_q[2] - p.cyc_q[1], 32'd3);
      chk_reg(ADDR_SRC0 + 8'h2, 8'h01);
      chk_reg(ADDR_CNT0, 8'h00);
      chk_reg(ADDR_STAT, 8'h35);
      chk({30'h0, term_irq_o}, 32'h1);
   endtask
   // channel 1 i/o to memory, decrementing, slow bus, edge-sensed request
   task automatic t_ch1();
      p.log_q.delete();
      slow <= 1'b1;
      wr_reg(ADDR_CTRL, 24'h07, 1);
      wr_reg(ADDR_IO1, 24'h1234, 2);
      wr_reg(ADDR_MEM1, 24'h000100, 3);
      wr_reg(ADDR_CNT1, 24'h2, 2);
      wr_reg(ADDR_STAT, 24'h80, 1);
      repeat (20) @(posedge clk_i);
      chk(p.log_q.size(), 32'd0);
      want <= 2'b10;
      // a held request is one edge, so only one byte may move
      repeat (40) @(posedge clk_i);
      chk(p.log_q.size(), 32'd1);
      want <= 2'b00;
      @(posedge clk_i);
      want <= 2'b10;
      wait_idle(8'h80);
      @(posedge clk_i);
      want <= 2'b00;
      slow <= 1'b0;
      chk_log(0, {2'b01, 20'h00100, 8'h6e});
      chk_log(1, {2'b00, 20'h000ff, 8'h6e});
      chk_reg(ADDR_STAT, 8'h31);
   endtask
   // both channels requested together: channel 0 goes first
   task automatic t_prio();
      p.log_q.delete();
      wr_reg(ADDR_SRC0, 24'h000050, 3);
      wr_reg(ADDR_DST0, 24'h000077, 3);
      wr_reg(ADDR_CNT0, 24'h1, 2);
      wr_reg(ADDR_MODE, 24'h30, 1);
      wr_reg(ADDR_CTRL, 24'h00, 1);
      wr_reg(ADDR_IO1, 24'h0099, 2);
      wr_reg(ADDR_MEM1, 24'h000200, 3);
      wr_reg(ADDR_CNT1, 24'h1, 2);
      want <= 2'b11;
      wr_reg(ADDR_STAT, 24'hc0, 1);
      wait_idle(8'hc0);
      @(posedge clk_i);
      want <= 2'b00;
      chk_log(0, {2'b10, 20'h00077, 8'h0a});
      chk_log(1, {2'b10, 20'h00099, 8'h5a});
   endtask
   // main enable, pause, gate bits and the termination interrupt
   task automatic t_nmi();
      wr_reg(ADDR_CNT0, 24'h1, 2);
      wr_reg(ADDR_STAT, 24'h40, 1);
      chk_reg(ADDR_STAT, 8'h71);
      pulse_nmi();
      chk_reg(ADDR_STAT, 8'h70);
      wr_reg(ADDR_STAT, 24'h40, 1);
      chk_reg(ADDR_STAT, 8'h71);
      wr_reg(ADDR_STAT, 24'h04, 1);
      chk_reg(ADDR_STAT, 8'h35);
      chk({30'h0, term_irq_o}, 32'h1);
      wr_reg(ADDR_STAT, 24'h54, 1);
      chk_reg(ADDR_STAT, 8'h35);
      pulse_nmi();
      wr_reg(ADDR_STAT, 24'h31, 1);
      chk_reg(ADDR_STAT, 8'h30);
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_burst();
      t_ch1();
      t_prio();
      t_nmi();
      wrap_up();
   end
endmodule // testbench
bind tdc_dma tdc_dma_monitor mon (.clk_i, .rst_i, .reg_addr_i, .reg_rdata_o, .bus_wait_i,
   .bus_addr_o, .bus_mem_o, .bus_io_o, .bus_rd_o, .bus_wr_o, .bus_hold_o, .transfer_end_n_o);
